//--- inc/bxc_defs.vh
`ifndef BXC_DEFS_VH
`define BXC_DEFS_VH

// ----------------------------------------
// Machine cycle lengths in T-states (one clk each), plus the T-state that latches read data
// ----------------------------------------
`define BXC_T_FETCH   3'h4
`define BXC_T_MEM     3'h3
`define BXC_T_ADDR    3'h5
`define BXC_T_RMWRD   3'h4
`define BXC_T_LATCH   3'h1

// ----------------------------------------
// Opcodes and encoding patterns
// ----------------------------------------
`define BXC_OP_PRE1   8'hDD
`define BXC_OP_PRE2   8'hFD
`define BXC_OP_XORM   8'hAE
`define BXC_OP_CPM    8'hBE
`define BXC_OP_XORN   8'hEE
`define BXC_OP_CPN    8'hFE
`define BXC_OP_INCM   8'h34
`define BXC_OP_DECM   8'h35
`define BXC_PAT_XOR   5'h15
`define BXC_PAT_CP    5'h17
`define BXC_PAT_IDC   2'h0
`define BXC_SFX_INC   3'h4
`define BXC_SFX_DEC   3'h5

// ----------------------------------------
// Register field codes, operation kinds and overflow operand values
// ----------------------------------------
`define BXC_RF_H      3'h4
`define BXC_RF_L      3'h5
`define BXC_RF_NONE   3'h6
`define BXC_RF_F      3'h6
`define BXC_RF_A      3'h7
`define BXC_K_XOR     2'h0
`define BXC_K_CP      2'h1
`define BXC_K_INC     2'h2
`define BXC_K_DEC     2'h3
`define BXC_OVF_INC   8'h7F
`define BXC_OVF_DEC   8'h80

// ----------------------------------------
// Flag bit positions
// ----------------------------------------
`define BXC_FS        7
`define BXC_FZ        6
`define BXC_FH        4
`define BXC_FPV       2
`define BXC_FN        1
`define BXC_FC        0

// ----------------------------------------
// Software register map (5-bit address)
// ----------------------------------------
`define BXC_A_IXL     5'h08
`define BXC_A_IXH     5'h09
`define BXC_A_IYL     5'h0A
`define BXC_A_IYH     5'h0B
`define BXC_A_PCL     5'h0C
`define BXC_A_PCH     5'h0D
`define BXC_A_CTRL    5'h0E
`define BXC_A_STAT    5'h0F
`define BXC_A_TLAST   5'h10
`define BXC_CTRL_RUN  0
`define BXC_ST_BUSY   0
`define BXC_ST_BAD    1
`define BXC_RST_BYTE  8'h00
`define BXC_RST_WORD  16'h0000

`endif

//--- rtl/bxc_alu.v
`timescale 1ns/1ps
`include "bxc_defs.vh"

module bxc_alu (
   input  wire [1:0] aluOp,     // Operation kind
   input  wire [7:0] acc,       // Accumulator value
   input  wire [7:0] opnd,      // Operand or target byte
   input  wire [7:0] flagsIn,   // Current flags
   output reg  [7:0] res,       // Result byte
   output reg  [7:0] flagsOut   // New flags
);

   wire [8:0] diff    = {1'b0, acc} - {1'b0, opnd};
   wire       halfBor = acc[3:0] < opnd[3:0];
   wire       ovfSub  = (acc[7] ^ opnd[7]) & (acc[7] ^ diff[7]);

   // ----------------------------------------
   // Result and flags per kind
   // ----------------------------------------
   always @* begin
      flagsOut = flagsIn;
      res      = acc;
      case (aluOp)
         `BXC_K_XOR: begin
            res                = acc ^ opnd;
            flagsOut[`BXC_FH]  = 1'b0;
            flagsOut[`BXC_FN]  = 1'b0;
            flagsOut[`BXC_FC]  = 1'b0;
            flagsOut[`BXC_FPV] = ~^res;
         end
         `BXC_K_CP: begin
            res                = diff[7:0];
            flagsOut[`BXC_FH]  = halfBor;
            flagsOut[`BXC_FPV] = ovfSub;
            flagsOut[`BXC_FN]  = 1'b1;
            flagsOut[`BXC_FC]  = diff[8];
         end
         `BXC_K_INC: begin
            res                = opnd + 8'h01;
            flagsOut[`BXC_FH]  = &opnd[3:0];
            flagsOut[`BXC_FPV] = opnd == `BXC_OVF_INC;
            flagsOut[`BXC_FN]  = 1'b0;
         end
         default: begin
            res                = opnd - 8'h01;
            flagsOut[`BXC_FH]  = ~|opnd[3:0];
            flagsOut[`BXC_FPV] = opnd == `BXC_OVF_DEC;
            flagsOut[`BXC_FN]  = 1'b1;
         end
      endcase
      // Sign and zero always track the byte result; carry kept on inc/dec
      flagsOut[`BXC_FS] = res[7];
      flagsOut[`BXC_FZ] = ~|res;
   end

endmodule // bxc_alu

//--- rtl/bxc_unit.v
// The strobed register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "bxc_defs.vh"

module bxc_unit (
   input  wire        clk,          // 125 MHz core clock
   input  wire        rst,          // Async reset, active high
   input  wire [4:0]  regAddr,      // Software register address
   input  wire [7:0]  regWrData,    // Software write data
   input  wire        regWr,        // Write strobe
   input  wire        regRd,        // Read strobe
   output reg  [7:0]  regRdData,    // Read data, cycle after strobe
   output reg  [15:0] memAddr,      // Memory address
   output reg         memRd,        // Memory read strobe
   output reg         memWr,        // Memory write strobe
   output reg  [7:0]  memWrData,    // Memory write data
   input  wire [7:0]  memRdData,    // Memory read data, cycle after strobe
   output reg         busy,         // Instruction in progress
   output reg         instrDone     // Pulse at end of each instruction
);

   // ----------------------------------------
   // States, one-hot
   // ----------------------------------------
   localparam S_IDLE  = 8'h01;
   localparam S_FETCH = 8'h02;
   localparam S_OPF   = 8'h04;
   localparam S_DISP  = 8'h08;
   localparam S_ADDR  = 8'h10;
   localparam S_IMM   = 8'h20;
   localparam S_MRD   = 8'h40;
   localparam S_MWR   = 8'h80;

   reg [7:0]  state_reg;
   reg [2:0]  tCnt_reg;
   reg [7:0]  dataLatch_reg;
   reg [7:0]  rf_reg [0:7];
   reg [15:0] ixReg_reg;
   reg [15:0] iyReg_reg;
   reg [15:0] pc_reg;
   reg [15:0] memPtr_reg;
   reg [1:0]  opKind_reg;
   reg        rmw_reg;
   reg        idxSel_reg;
   reg        run_reg;
   reg        bad_reg;
   reg [7:0]  tTot_reg;
   reg [7:0]  lastTs_reg;
   reg [2:0]  len_next;
   integer    i;

   // ----------------------------------------
   // Opcode decode on the latched byte
   // ----------------------------------------
   wire [7:0] opc      = dataLatch_reg;
   wire       isPre    = opc == `BXC_OP_PRE1 || opc == `BXC_OP_PRE2;
   wire       isRegAlu = (opc[7:3] == `BXC_PAT_XOR || opc[7:3] == `BXC_PAT_CP)
                         && opc[2:0] != `BXC_RF_NONE;
   wire       isRegIdc = opc[7:6] == `BXC_PAT_IDC && opc[5:3] != `BXC_RF_NONE
                         && (opc[2:0] == `BXC_SFX_INC
                             || opc[2:0] == `BXC_SFX_DEC);
   wire       isRmwOp  = opc == `BXC_OP_INCM || opc == `BXC_OP_DECM;
   wire       isMem    = isRmwOp || opc == `BXC_OP_XORM
                         || opc == `BXC_OP_CPM;
   wire       isImm    = opc == `BXC_OP_XORN || opc == `BXC_OP_CPN;
   // Kind falls out of two opcode bits; field position depends on group
   wire [1:0] dKind    = opc[7] ? {1'b0, opc[4]} : {1'b1, opc[0]};
   wire [2:0] dField   = opc[7] ? opc[2:0] : opc[5:3];
   wire [15:0] ptrPair = {rf_reg[`BXC_RF_H], rf_reg[`BXC_RF_L]};
   // Sign-extend the displacement; 16-bit sum wraps by itself
   wire [15:0] idxAddr = (idxSel_reg ? iyReg_reg : ixReg_reg)
                         + {{8{dataLatch_reg[7]}}, dataLatch_reg};

   // ----------------------------------------
   // Arithmetic unit hookup
   // ----------------------------------------
   wire       inFetch = state_reg == S_FETCH;
   wire [1:0] aluOp   = inFetch ? dKind : opKind_reg;
   wire [7:0] aluB    = inFetch ? rf_reg[dField] : dataLatch_reg;
   wire [7:0] aluRes;
   wire [7:0] aluF;

   bxc_alu u_alu (
      .aluOp    (aluOp),
      .acc      (rf_reg[`BXC_RF_A]),
      .opnd     (aluB),
      .flagsIn  (rf_reg[`BXC_RF_F]),
      .res      (aluRes),
      .flagsOut (aluF)
   );

   // ----------------------------------------
   // Length of the current machine cycle
   // ----------------------------------------
   always @* begin
      case (state_reg)
         S_FETCH: len_next = `BXC_T_FETCH;
         S_OPF:   len_next = `BXC_T_FETCH;
         S_ADDR:  len_next = `BXC_T_ADDR;
         S_MRD:   len_next = rmw_reg ? `BXC_T_RMWRD : `BXC_T_MEM;
         default: len_next = `BXC_T_MEM;
      endcase
   end

   wire lastT   = tCnt_reg == len_next - 3'h1;
   wire rdState = state_reg == S_FETCH || state_reg == S_OPF || state_reg == S_DISP
                  || state_reg == S_IMM || state_reg == S_MRD;

   // Ends an instruction and chains the next fetch while running
   task finish;
      begin
         instrDone <= 1'b1;
         lastTs_reg <= tTot_reg + 8'h01;
         tTot_reg  <= 8'h00;
         tCnt_reg  <= 3'h0;
         if (run_reg) begin
            state_reg <= S_FETCH;
            memRd     <= 1'b1;
            memAddr   <= pc_reg;
            pc_reg    <= pc_reg + 16'h0001;
         end else begin
            state_reg <= S_IDLE;
            busy      <= 1'b0;
         end
      end
   endtask

   // Starts a memory read machine cycle
   task startRead;
      input [7:0]  nextState;
      input [15:0] addr;
      begin
         state_reg <= nextState;
         tCnt_reg  <= 3'h0;
         memRd     <= 1'b1;
         memAddr   <= addr;
      end
   endtask

   // Register-form or immediate result write-back
   task execWrite;
      input [2:0] field;
      begin
         rf_reg[`BXC_RF_F] <= aluF;
         if (aluOp == `BXC_K_XOR)
            rf_reg[`BXC_RF_A] <= aluRes;
         else if (aluOp != `BXC_K_CP)
            rf_reg[field] <= aluRes;
      end
   endtask

   // ----------------------------------------
   // Sequencer, register file and bus writes
   // ----------------------------------------
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         state_reg     <= S_IDLE;
         tCnt_reg      <= 3'h0;
         dataLatch_reg <= `BXC_RST_BYTE;
         for (i = 0; i < 8; i = i + 1) begin
            rf_reg[i] <= `BXC_RST_BYTE;
         end
         ixReg_reg     <= `BXC_RST_WORD;
         iyReg_reg     <= `BXC_RST_WORD;
         pc_reg        <= `BXC_RST_WORD;
         memPtr_reg    <= `BXC_RST_WORD;
         opKind_reg    <= `BXC_K_XOR;
         rmw_reg       <= 1'b0;
         idxSel_reg    <= 1'b0;
         run_reg       <= 1'b0;
         bad_reg       <= 1'b0;
         tTot_reg      <= 8'h00;
         lastTs_reg    <= 8'h00;
         memAddr       <= `BXC_RST_WORD;
         memRd         <= 1'b0;
         memWr         <= 1'b0;
         memWrData     <= `BXC_RST_BYTE;
         busy          <= 1'b0;
         instrDone     <= 1'b0;
      end else begin
         memRd     <= 1'b0;
         memWr     <= 1'b0;
         instrDone <= 1'b0;
         // Software writes first so the sequencer wins a same-cycle clash
         if (regWr) begin
            if (regAddr[4:3] == 2'h0)
               rf_reg[regAddr[2:0]] <= regWrData;
            case (regAddr)
               `BXC_A_IXL:  ixReg_reg[7:0]  <= regWrData;
               `BXC_A_IXH:  ixReg_reg[15:8] <= regWrData;
               `BXC_A_IYL:  iyReg_reg[7:0]  <= regWrData;
               `BXC_A_IYH:  iyReg_reg[15:8] <= regWrData;
               `BXC_A_PCL:  pc_reg[7:0]     <= regWrData;
               `BXC_A_PCH:  pc_reg[15:8]    <= regWrData;
               `BXC_A_CTRL: begin
                  run_reg <= regWrData[`BXC_CTRL_RUN];
                  bad_reg <= 1'b0;
               end
               default: ;
            endcase
         end
         if (state_reg != S_IDLE) begin
            tCnt_reg <= tCnt_reg + 3'h1;
            tTot_reg <= tTot_reg + 8'h01;
         end
         // Memory answers one cycle after the strobe
         if (rdState && tCnt_reg == `BXC_T_LATCH)
            dataLatch_reg <= memRdData;
         case (state_reg)
            // Leave rest only when software has set run
            S_IDLE: begin
               if (run_reg) begin
                  startRead(S_FETCH, pc_reg);
                  pc_reg   <= pc_reg + 16'h0001;
                  tTot_reg <= 8'h00;
                  busy     <= 1'b1;
               end
            end
            // Opcode in hand: decode and choose the next machine cycle
            S_FETCH: begin
               if (lastT) begin
                  opKind_reg <= dKind;
                  rmw_reg    <= isRmwOp;
                  if (isPre) begin
                     idxSel_reg <= opc == `BXC_OP_PRE2;
                     startRead(S_OPF, pc_reg);
                     pc_reg <= pc_reg + 16'h0001;
                  end else if (isRegAlu || isRegIdc) begin
                     execWrite(dField);
                     finish;
                  end else if (isImm) begin
                     startRead(S_IMM, pc_reg);
                     pc_reg <= pc_reg + 16'h0001;
                  end else if (isMem) begin
                     memPtr_reg <= ptrPair;
                     startRead(S_MRD, ptrPair);
                  end else begin
                     // Unknown opcode: stop rather than guess its length
                     bad_reg <= 1'b1;
                     run_reg <= 1'b0;
                     state_reg <= S_IDLE;
                     busy      <= 1'b0;
                     tCnt_reg  <= 3'h0;
                  end
               end
            end
            // After a prefix only the memory forms are legal
            S_OPF: begin
               if (lastT) begin
                  opKind_reg <= dKind;
                  rmw_reg    <= isRmwOp;
                  if (isMem) begin
                     startRead(S_DISP, pc_reg);
                     pc_reg <= pc_reg + 16'h0001;
                  end else begin
                     bad_reg   <= 1'b1;
                     run_reg   <= 1'b0;
                     state_reg <= S_IDLE;
                     busy      <= 1'b0;
                     tCnt_reg  <= 3'h0;
                  end
               end
            end
            // Index register is only read here, never written back
            S_DISP: begin
               if (lastT) begin
                  memPtr_reg <= idxAddr;
                  state_reg  <= S_ADDR;
                  tCnt_reg   <= 3'h0;
               end
            end
            // Idle T-states stand in for the address adder
            S_ADDR: begin
               if (lastT)
                  startRead(S_MRD, memPtr_reg);
            end
            // Immediate byte is the operand of exclusive-OR or compare
            S_IMM: begin
               if (lastT) begin
                  execWrite(`BXC_RF_A);
                  finish;
               end
            end
            // Flags settle here; a read-modify-write writes back next
            S_MRD: begin
               if (lastT) begin
                  rf_reg[`BXC_RF_F] <= aluF;
                  if (rmw_reg) begin
                     state_reg <= S_MWR;
                     tCnt_reg  <= 3'h0;
                     memWr     <= 1'b1;
                     memAddr   <= memPtr_reg;
                     memWrData <= aluRes;
                  end else begin
                     if (opKind_reg == `BXC_K_XOR)
                        rf_reg[`BXC_RF_A] <= aluRes;
                     finish;
                  end
               end
            end
            // Write cycle runs its full length before the end pulse
            S_MWR: begin
               if (lastT)
                  finish;
            end
            // Stray state code falls back to rest
            default: begin
               state_reg <= S_IDLE;
               busy      <= 1'b0;
            end
         endcase
      end
   end

   // ----------------------------------------
   // Software read port; zero outside the answer cycle
   // ----------------------------------------
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         regRdData <= `BXC_RST_BYTE;
      end else begin
         regRdData <= `BXC_RST_BYTE;
         if (regRd) begin
            if (regAddr[4:3] == 2'h0)
               regRdData <= rf_reg[regAddr[2:0]];
            case (regAddr)
               `BXC_A_IXL:   regRdData <= ixReg_reg[7:0];
               `BXC_A_IXH:   regRdData <= ixReg_reg[15:8];
               `BXC_A_IYL:   regRdData <= iyReg_reg[7:0];
               `BXC_A_IYH:   regRdData <= iyReg_reg[15:8];
               `BXC_A_PCL:   regRdData <= pc_reg[7:0];
               `BXC_A_PCH:   regRdData <= pc_reg[15:8];
               `BXC_A_CTRL:  regRdData <= {7'h00, run_reg};
               `BXC_A_STAT:  regRdData <= {6'h00, bad_reg, busy};
               `BXC_A_TLAST: regRdData <= lastTs_reg;
               default: ;
            endcase
         end
      end
   end

endmodule // bxc_unit

//--- dv/bxc_unit_props.sv
`timescale 1ns/1ps

module bxc_unit_props (
   input wire        clk,        // Core clock
   input wire        rst,        // Async reset
   input wire [4:0]  regAddr,    // Register address
   input wire [7:0]  regWrData,  // Register write data
   input wire        regWr,      // Write strobe
   input wire        regRd,      // Read strobe
   input wire [7:0]  regRdData,  // Read data
   input wire [15:0] memAddr,    // Memory address
   input wire        memRd,      // Memory read strobe
   input wire        memWr,      // Memory write strobe
   input wire [7:0]  memWrData,  // Memory write data
   input wire [7:0]  memRdData,  // Memory read data
   input wire        busy,       // Running
   input wire        instrDone   // End pulse
);
   // ----------------------------------------
   // Timing relations at the memory and register ports
   // ----------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   // Write-back is the last cycle with traffic; the end pulse follows three cycles on
   sequence sQuietTail;
      (!memWr && !memRd)[*2] ##1 instrDone;
   endsequence

   // No memory cycle is shorter than three T-states
   sequence sFetchGap;
      !memRd[*2];
   endsequence

   a_wr_same_addr: assert property (
      memWr |-> $past(memRd, 4) && memAddr == $past(memAddr, 4))
      else $error("write-back address differs from the read address");
   a_wr_step_one: assert property (
      memWr |-> (memWrData == $past(memRdData, 3) + 8'h01)
                || (memWrData == $past(memRdData, 3) - 8'h01))
      else $error("write-back byte is not the read byte plus or minus one");
   a_wr_then_done: assert property (memWr |=> sQuietTail)
      else $error("end pulse not three cycles after write-back");
   a_rd_min_gap: assert property (memRd |=> sFetchGap)
      else $error("memory read strobes closer than three cycles");
   a_done_spacing: assert property (instrDone |=> !instrDone[*3])
      else $error("instructions shorter than four T-states");
   a_done_cause: assert property (
      instrDone |-> $past(memRd, 3) || $past(memRd, 4) || $past(memWr, 3))
      else $error("end pulse not placed after the last machine cycle");
   a_rdata_idle: assert property (!$past(regRd) |-> regRdData == 8'h00)
      else $error("read data not zero outside the answer cycle");
   a_rdata_unmap: assert property (regRd && regAddr > 5'h10 |=> regRdData == 8'h00)
      else $error("unmapped address returned data");
endmodule // bxc_unit_props

bind bxc_unit bxc_unit_props u_props (.clk(clk), .rst(rst), .regAddr(regAddr),
   .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
   .memAddr(memAddr), .memRd(memRd), .memWr(memWr), .memWrData(memWrData),
   .memRdData(memRdData), .busy(busy), .instrDone(instrDone));

//--- dv/bxc_mem_model.sv
`timescale 1ns/1ps

module bxc_mem_model (
   input  wire        clk,        // Core clock
   input  wire [15:0] memAddr,    // Access address
   input  wire        memRd,      // Read strobe
   input  wire        memWr,      // Write strobe
   input  wire [7:0]  memWrData,  // Write data
   output reg  [7:0]  memRdData   // Read data, cycle after strobe
);
   reg [7:0] mem [0:65535];
   integer   i;

   initial begin
      memRdData = 8'h00;
      for (i = 0; i < 65536; i = i + 1) mem[i] = 8'h00;
   end

   // ----------------------------------------
   // Same-clock memory
   // ----------------------------------------
   // Outside the answer cycle the lines flip, so a sample one cycle late sees the inverted byte
   always @(posedge clk) begin
      if (memWr) mem[memAddr] <= memWrData;
      if (memRd) memRdData <= mem[memAddr];
      else memRdData <= ~memRdData;
   end
endmodule // bxc_mem_model

//--- dv/byte_xor_compare_incdec_unit_test.sv
`timescale 1ns/1ps
`include "bxc_defs.vh"

module byte_xor_compare_incdec_unit_test;
   localparam [47:0] CORNER = 48'h7F800F1000FF;
   reg         clk;
   reg         rst;
   reg  [4:0]  regAddr;
   reg  [7:0]  regWrData;
   reg         regWr;
   reg         regRd;
   wire [7:0]  regRdData;
   wire [15:0] memAddr;
   wire        memRd;
   wire        memWr;
   wire [7:0]  memWrData;
   wire [7:0]  memRdData;
   wire        busy;
   wire        instrDone;
   integer     err_total;
   integer     comparisons;
   integer     cycles;
   integer     lenCnt;
   integer     lenSeen;
   integer     n;
   reg         armed;
   reg  [7:0]  rv [0:7];
   reg  [7:0]  tmp;
   reg  [7:0]  opv;

   bxc_unit u_dut (.clk(clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
      .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .memAddr(memAddr), .memRd(memRd),
      .memWr(memWr), .memWrData(memWrData), .memRdData(memRdData), .busy(busy),
      .instrDone(instrDone));
   bxc_mem_model u_mem (.clk(clk), .memAddr(memAddr), .memRd(memRd), .memWr(memWr),
      .memWrData(memWrData), .memRdData(memRdData));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // ----------------------------------------
   // Cycle counts and run-away guard
   // ----------------------------------------
   // Counts from the first fetch strobe to the end pulse, independent of the status count
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (lenCnt != 0) lenCnt <= lenCnt + 1;
      if (memRd && armed) begin
         lenCnt <= 1;
         armed  <= 1'b0;
      end
      if (instrDone && lenCnt != 0) begin
         lenSeen <= lenCnt;
         lenCnt  <= 0;
      end
      if (cycles == 40000) begin
         err_total = err_total + 1;
         close_out;
      end
   end

   task close_out;
      begin
         $display("Mismatches %0d of %0d comparisons", err_total, comparisons);
         if (err_total == 0 && comparisons > 0)
            $display("Simulation passed");
         else
            $display("Simulation failed");
         $finish;
      end
   endtask

   task check(input [63:0] what, input [15:0] exp, input [15:0] got);
      begin
         comparisons = comparisons + 1;
         if (got !== exp) begin
            err_total = err_total + 1;
            $display("BAD %0s expected %h seen %h", what, exp, got);
         end
      end
   endtask

   task wr(input [4:0] a, input [7:0] d);
      begin
         @(posedge clk);
         regAddr   <= a;
         regWrData <= d;
         regWr     <= 1'b1;
         @(posedge clk);
         regWr <= 1'b0;
      end
   endtask

   task rd(input [4:0] a, output [7:0] d);
      begin
         @(posedge clk);
         regAddr <= a;
         regRd   <= 1'b1;
         @(posedge clk);
         regRd <= 1'b0;
         #1;
         d = regRdData;
      end
   endtask

   // Result in the high byte, new flags in the low byte; unused flag bits ride through
   function [15:0] ref_op(input [1:0] k, input [7:0] a, input [7:0] s, input [7:0] f);
      reg [7:0] r;
      reg [7:0] g;
      begin
         g = f;
         r = (k == `BXC_K_XOR) ? (a ^ s) : (k == `BXC_K_CP) ? (a - s) :
             (k == `BXC_K_INC) ? (s + 8'h01) : (s - 8'h01);
         g[`BXC_FS] = r[7];
         g[`BXC_FZ] = (r == 8'h00);
         g[`BXC_FH] = (k == `BXC_K_XOR) ? 1'b0 : (k == `BXC_K_CP) ? (a[3:0] < s[3:0]) :
            (k == `BXC_K_INC) ? (s[3:0] == 4'hF) : (s[3:0] == 4'h0);
         g[`BXC_FPV] = (k == `BXC_K_XOR) ? ~^r : (k == `BXC_K_CP) ? ((a[7] ^ s[7]) & (a[7] ^ r[7]))
            : (k == `BXC_K_INC) ? (s == 8'h7F) : (s == 8'h80);
         g[`BXC_FN] = (k == `BXC_K_CP) || (k == `BXC_K_DEC);
         if (k <= `BXC_K_CP) g[`BXC_FC] = (k == `BXC_K_CP) && (a < s);
         ref_op = {r, g};
      end
   endfunction

   // ----------------------------------------
   // One instruction: set up, run alone, read everything back
   // ----------------------------------------
   // Forms: 0 register, 1 immediate, 2 pointer pair, 3 first index, 4 second index
   task run_one(input [1:0] k, input integer fIn, input [7:0] v, input eqA);
      reg [2:0]  f;
      reg [15:0] ix;
      reg [15:0] tgt;
      reg [7:0]  d;
      reg [15:0] res;
      reg [7:0]  ex [0:7];
      reg [4:0]  ia;
      integer    i;
      integer    form;
      integer    len;
      begin
         form = (k >= `BXC_K_INC && fIn == 1) ? 0 : fIn;
         f = $urandom % 7;
         if (f == `BXC_RF_NONE) f = `BXC_RF_A;
         for (i = 0; i < 8; i = i + 1) rv[i] = $urandom;
         rv[`BXC_RF_H][7] = 1'b1; // Keeps the pointer clear of the program bytes
         ix = $urandom;
         ix[15] = 1'b1;
         ix[14] = 1'b0; // Indexed target can never wrap onto the program bytes
         d = $urandom;
         ia = (form == 4) ? `BXC_A_IYL : `BXC_A_IXL;
         tgt = (form >= 3) ? ix + {{8{d[7]}}, d} : {rv[`BXC_RF_H], rv[`BXC_RF_L]};
         if (eqA) rv[`BXC_RF_A] = v;
         if (form == 0) rv[f] = v;
         else if (form >= 2) u_mem.mem[tgt] = v;
         i = 0;
         if (form >= 3) begin
            u_mem.mem[0] = (form == 3) ? `BXC_OP_PRE1 : `BXC_OP_PRE2;
            i = 1;
         end
         u_mem.mem[i] = (form == 1) ? ((k == `BXC_K_XOR) ? `BXC_OP_XORN : `BXC_OP_CPN) :
            (k == `BXC_K_XOR) ? {`BXC_PAT_XOR, (form >= 2) ? `BXC_RF_NONE : f} :
            (k == `BXC_K_CP) ? {`BXC_PAT_CP, (form >= 2) ? `BXC_RF_NONE : f} :
            {`BXC_PAT_IDC, (form >= 2) ? `BXC_RF_NONE : f,
             (k == `BXC_K_INC) ? `BXC_SFX_INC : `BXC_SFX_DEC};
         u_mem.mem[i + 1] = (form == 1) ? v : d;
         for (i = 0; i < 8; i = i + 1) wr(i[4:0], rv[i]);
         wr(ia, ix[7:0]);
         wr(ia + 5'h01, ix[15:8]);
         wr(`BXC_A_PCL, 8'h00);
         wr(`BXC_A_PCH, 8'h00);
         lenSeen = 0; // A stale length from the last run must not pass
         armed = 1'b1;
         wr(`BXC_A_CTRL, 8'h01);
         wr(`BXC_A_CTRL, 8'h00); // Current instruction finishes, then the unit idles
         for (i = 0; i < 40 && busy !== 1'b0; i = i + 1) @(posedge clk);
         @(posedge clk);
         res = ref_op(k, rv[`BXC_RF_A], (form == 0) ? rv[f] : v, rv[`BXC_RF_F]);
         for (i = 0; i < 8; i = i + 1) ex[i] = rv[i];
         ex[`BXC_RF_F] = res[7:0];
         if (k == `BXC_K_XOR) ex[`BXC_RF_A] = res[15:8];
         if (k >= `BXC_K_INC && form == 0) ex[f] = res[15:8];
         for (i = 0; i < 8; i = i + 1) begin
            rd(i[4:0], tmp);
            check("register", ex[i], tmp);
         end
         if (form >= 2 && k >= `BXC_K_INC)
            check("memory", res[15:8], u_mem.mem[tgt]);
         rd(ia, tmp);
         check("index lo", ix[7:0], tmp);
         rd(ia + 5'h01, tmp);
         check("index hi", ix[15:8], tmp);
         len = (form == 0) ? 4 : (form >= 3) ? ((k <= `BXC_K_CP) ? 19 : 23) :
            ((k <= `BXC_K_CP) ? 7 : 11);
         check("length", len[15:0], lenSeen[15:0]);
         rd(`BXC_A_TLAST, tmp);
         check("count", len[15:0], tmp);
      end
   endtask

   initial begin
      rst = 1'b1;
      regAddr = 5'h00;
      regWrData = 8'h00;
      regWr = 1'b0;
      regRd = 1'b0;
      err_total = 0;
      comparisons = 0;
      cycles = 0;
      lenCnt = 0;
      lenSeen = 0;
      armed = 1'b0;
      n = $urandom(5045);
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      // Corner operands first, then random ones; every kind meets every form, except that inc/dec run the register form in place of immediate
      for (n = 0; n < 80; n = n + 1) begin
         opv = (n < 40) ? CORNER[8 * (n % 6) +: 8] : $urandom;
         run_one(n[1:0], (n / 4) % 5, opv, (n % 7) == 0);
      end
      // A prefix followed by a foreign opcode stops the unit with the error bit
      u_mem.mem[0] = `BXC_OP_PRE1;
      u_mem.mem[1] = 8'h00;
      wr(`BXC_A_PCL, 8'h00);
      wr(`BXC_A_CTRL, 8'h01);
      repeat (30) @(posedge clk);
      rd(`BXC_A_STAT, tmp);
      check("status", 8'h02, tmp);
      wr(`BXC_A_CTRL, 8'h00);
      rd(`BXC_A_STAT, tmp);
      check("status", 8'h00, tmp);
      rd(5'h1F, tmp);
      check("unmapped", 8'h00, tmp);
      close_out;
   end
endmodule // byte_xor_compare_incdec_unit_test
